// ==== bench/frio_regs_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module frio_regs_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [3:0] io_pin_oe_n,
  input wire logic breath_demod_enable,
  input wire logic breath_mod_enable,
  input wire logic [1:0] odd_amp_channel_sel,
  input wire logic [1:0] even_amp_channel_sel,
  input wire logic pulse_buffer_powerdown,
  input wire logic center_amp_a_powerdown,
  input wire logic center_amp_b_powerdown,
  input wire logic center_amp_c_powerdown,
  input wire logic central_terminal_drive,
  input wire logic [15:0] channel_source
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire [2:0] pd_all = {center_amp_a_powerdown, center_amp_b_powerdown,
    center_amp_c_powerdown};
  wire [4:0] pace_all = {even_amp_channel_sel, odd_amp_channel_sel,
    pulse_buffer_powerdown};
  wire breathing_measure_ctrl_on = breath_demod_enable || breath_mod_enable;
  a_breathing_measure_ctrl_pins: assert property (breathing_measure_ctrl_on ##1 breathing_measure_ctrl_on
    |-> io_pin_oe_n == 4'hF)
    else $error("pins driven in respiration");
  // Sampled reset guards the first edge after release
  a_ct_drive: assert property (rst_n && $stable(pd_all)
    ##1 $stable(pd_all) |-> central_terminal_drive == !(&pd_all))
    else $error("terminal drive wrong");
  a_pace_only: assert property (!$stable(pace_all)
    |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pace outputs moved without write");
  a_src_legal: assert property (channel_source inside
    {16'h5555, 16'hAABA, 16'h0000})
    else $error("channel source illegal");
  // Both halves sit held one cycle before the response rises
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read data late");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_b_single: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
endmodule
bind frio_regs frio_regs_properties u_frio_regs_properties (
  .clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .io_pin_oe_n(io_pin_oe_n), .breath_demod_enable(breath_demod_enable),
  .breath_mod_enable(breath_mod_enable),
  .odd_amp_channel_sel(odd_amp_channel_sel),
  .even_amp_channel_sel(even_amp_channel_sel),
  .pulse_buffer_powerdown(pulse_buffer_powerdown),
  .center_amp_a_powerdown(center_amp_a_powerdown),
  .center_amp_b_powerdown(center_amp_b_powerdown),
  .center_amp_c_powerdown(center_amp_c_powerdown),
  .central_terminal_drive(central_terminal_drive),
  .channel_source(channel_source)
);
`default_nettype wire

// ==== bench/frontend_routing_io_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module frontend_routing_io_regs_bench;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [7:0] e;
    logic [15:0] cs;} frio_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb, io_pin_i, io_pin_o, io_pin_oe_n;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, breath_control;
  logic [1:0] odd_amp_channel_sel, even_amp_channel_sel;
  logic pulse_buffer_powerdown, breath_demod_enable, breath_mod_enable;
  logic breath_mod_reference, leg_lead_to_ch6, left_arm_lead_to_ch5;
  logic right_arm_lead_to_ch7, right_arm_lead_to_ch4;
  logic [2:0] breath_phase, center_amp_a_select, center_amp_b_select;
  logic [2:0] center_amp_c_select;
  logic center_amp_a_powerdown, center_amp_b_powerdown;
  logic center_amp_c_powerdown, central_terminal_drive;
  logic [15:0] channel_source;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  // The first two rows carry junk in the upper data bytes: only the low byte may land
  frio_row_s rows [11] = '{
    '{8'h50, 32'hFFFF_FFA5, 8'hA5, 16'h5555},
    '{8'h54, 32'hFFFF_FFFF, 8'h1F, 16'h5555},
    '{8'h54, 32'h0000_000A, 8'h0A, 16'h5555},
    '{8'h58, 32'h0000_003F, 8'h3F, 16'h5555},
    '{8'h60, 32'h0000_005A, 8'h5A, 16'h5555},
    '{8'h60, 32'h0000_00A5, 8'hA5, 16'h5555},
    '{8'h64, 32'h0000_00C3, 8'hC3, 16'h5555},
    '{8'h64, 32'h0000_003C, 8'h3C, 16'h5555},
    '{8'h68, 32'h0000_00FB, 8'h03, 16'hAABA},
    '{8'h68, 32'h0000_0005, 8'h05, 16'h0000},
    '{8'h68, 32'h0000_0000, 8'h00, 16'h5555}};
  logic [7:0] ra [6] = '{8'h50, 8'h54, 8'h58, 8'h60, 8'h64, 8'h68};

  frio_regs u_frio_regs (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .io_pin_i(io_pin_i),
    .io_pin_o(io_pin_o), .io_pin_oe_n(io_pin_oe_n),
    .odd_amp_channel_sel(odd_amp_channel_sel),
    .even_amp_channel_sel(even_amp_channel_sel),
    .pulse_buffer_powerdown(pulse_buffer_powerdown),
    .breath_demod_enable(breath_demod_enable),
    .breath_mod_enable(breath_mod_enable),
    .breath_mod_reference(breath_mod_reference),
    .breath_phase(breath_phase), .breath_control(breath_control),
    .leg_lead_to_ch6(leg_lead_to_ch6),
    .left_arm_lead_to_ch5(left_arm_lead_to_ch5),
    .right_arm_lead_to_ch7(right_arm_lead_to_ch7),
    .right_arm_lead_to_ch4(right_arm_lead_to_ch4),
    .center_amp_a_powerdown(center_amp_a_powerdown),
    .center_amp_a_select(center_amp_a_select),
    .center_amp_b_powerdown(center_amp_b_powerdown),
    .center_amp_b_select(center_amp_b_select),
    .center_amp_c_powerdown(center_amp_c_powerdown),
    .center_amp_c_select(center_amp_c_select),
    .central_terminal_drive(central_terminal_drive),
    .channel_source(channel_source)
  );

  always #25 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  // Outputs packed in the same bit order as their register
  function automatic logic [7:0] outs(input logic [7:0] a);
    case (a)
      8'h50: outs = {io_pin_o, io_pin_oe_n};
      8'h54: outs = {3'h0, even_amp_channel_sel, odd_amp_channel_sel,
        pulse_buffer_powerdown};
      8'h58: outs = {breath_demod_enable, breath_mod_enable,
        breath_mod_reference, breath_phase, breath_control};
      8'h60: outs = {leg_lead_to_ch6, left_arm_lead_to_ch5,
        right_arm_lead_to_ch7, right_arm_lead_to_ch4,
        center_amp_a_powerdown, center_amp_a_select};
      default: outs = {center_amp_c_powerdown, center_amp_b_powerdown,
        center_amp_b_select, center_amp_c_select};
    endcase
  endfunction

  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, io_pin_i} <= '0;
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d, 4'hF);
      chk("bresp", {30'h0, rs}, 32'h0);
      rd(rows[i].a);
      chk("rdata", rv, {24'h0, rows[i].e});
      if (rows[i].a != 8'h68)
        chk("outs", {24'h0, outs(rows[i].a)}, {24'h0, rows[i].e});
      chk("src", {16'h0, channel_source}, {16'h0, rows[i].cs});
    end
    // Only the two enable bits may take the pins
    wr(8'h50, 32'hA0, 4'hF);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h58, 32'h80 >> i, 4'hF);
      rd(8'h6C);
      chk("pin_dir", {28'h0, io_pin_oe_n}, i < 2 ? 32'hF : 32'h0);
      chk("pin_state", rv, i < 2 ? 32'h0 : 32'hA);
    end
    chk("pin_out", {28'h0, io_pin_o}, 32'hA);
    wr(8'h50, 32'h0F, 4'hF);
    io_pin_i <= 4'h9;
    repeat (6) @(posedge clk);
    rd(8'h6C);
    chk("pin_in", rv, 32'h9);
    wr(8'h5C, 32'hFF, 4'hF);
    chk("bresp_bad", {30'h0, rs}, 32'h2);
    rd(8'h5C);
    chk("rd_bad", {rv[29:0], rs}, 32'h2);
    wr(8'h51, 32'hF0, 4'hF);
    chk("bresp_odd", {30'h0, rs}, 32'h2);
    wr(8'h50, 32'hF0, 4'h0);
    wr(8'h6C, 32'hF0, 4'hF);
    rd(8'h50);
    chk("io_kept", rv, 32'h0F);
    wr(8'h60, 32'h08, 4'hF);
    wr(8'h64, 32'hC0, 4'hF);
    repeat (2) @(posedge clk);
    chk("ct_off", {31'h0, central_terminal_drive}, 32'h0);
    wr(8'h64, 32'h40, 4'hF);
    repeat (2) @(posedge clk);
    chk("ct_on", {31'h0, central_terminal_drive}, 32'h1);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("rst_dir", {28'h0, io_pin_oe_n}, 32'hF);
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk("rst_val", rv, i == 0 ? 32'hF : 32'h0);
    end
    chk("rst_src", {16'h0, channel_source}, 32'h5555);
    complete_run;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      complete_run;
    end
  end
endmodule
`default_nettype wire

// ==== src/frio_pin_ctl.sv ====
`timescale 1ns/1ps
`default_nettype none
module frio_pin_ctl (
  input wire logic clk,
  input wire logic rst_n,
  frio_pins_if.pad pins
);
  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s3;
  logic [3:0] held;

  // Three stages; a change counts once the last two agree
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 4'h0;
    end
    else
    begin
      s1 <= pins.pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      held <= 4'h0;
    else
      held <= (s2 & s3) | (held & (s2 | s3));
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pins.pin_o <= 4'h0;
      pins.pin_oe_n <= 4'hF;
    end
    else if (pins.breathing_measure_ctrl_active)
    begin
      // Respiration owns the pins; release drive
      pins.pin_o <= 4'h0;
      pins.pin_oe_n <= 4'hF;
    end
    else
    begin
      pins.pin_o <= pins.value;
      pins.pin_oe_n <= pins.dir_in;
    end
  end

  // Outside respiration, inputs show pad level, outputs show driven value; in it, all read 0
  assign pins.read_back = pins.breathing_measure_ctrl_active ? 4'h0 :
    ((held & pins.dir_in) | (pins.value & ~pins.dir_in));
endmodule
`default_nettype wire

// ==== src/frio_pins_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface frio_pins_if;
  logic breathing_measure_ctrl_active;
  logic [3:0] value;
  logic [3:0] dir_in;
  logic [3:0] pin_i;
  logic [3:0] pin_o;
  logic [3:0] pin_oe_n;
  logic [3:0] read_back;
  modport ctl (output breathing_measure_ctrl_active, value, dir_in, input read_back);
  modport pad (input breathing_measure_ctrl_active, value, dir_in, pin_i,
    output pin_o, pin_oe_n, read_back);
endinterface
`default_nettype wire

// ==== src/frio_pkg.sv ====
`default_nettype none
package frio_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  // Printed offsets are not all multiples of four: they are indices
  localparam logic [7:0] IDX_IO_PINS = 8'h14;
  localparam logic [7:0] IDX_PACE = 8'h15;
  localparam logic [7:0] IDX_BREATH = 8'h16;
  localparam logic [7:0] IDX_CT_AUG = 8'h18;
  localparam logic [7:0] IDX_CT_BC = 8'h19;
  localparam logic [7:0] IDX_MUX_SEL = 8'h1A;
  localparam logic [7:0] IDX_PIN_STATE = 8'h1B;
  localparam logic [7:0] RST_IO_PINS = 8'h0F;
  localparam logic [7:0] RST_PACE = 8'h00;
  localparam logic [7:0] RST_BREATH = 8'h00;
  localparam logic [7:0] RST_CT_AUG = 8'h00;
  localparam logic [7:0] RST_CT_BC = 8'h00;
  localparam logic [7:0] RST_MUX_SEL = 8'h00;
  localparam logic [7:0] MASK_PACE = 8'h1F;
  localparam logic [7:0] MASK_MUX_SEL = 8'h07;
  localparam int PIN_VAL_LSB = 4;
  localparam int PACE_PD_BIT = 0;
  localparam int PACE_ODD_LSB = 1;
  localparam int PACE_EVEN_LSB = 3;
  localparam int BR_DEMOD_BIT = 7;
  localparam int BR_MOD_BIT = 6;
  localparam int BR_REF_BIT = 5;
  localparam int BR_PH_LSB = 2;
  localparam int BR_CTRL_LSB = 0;
  localparam int CT_PD_A_BIT = 3;
  localparam int CT_PD_C_BIT = 7;
  localparam int CT_PD_B_BIT = 6;
  localparam int CT_SEL_B_LSB = 3;
  localparam int CT_SEL_C_LSB = 0;
  localparam logic [2:0] MUX_NORMAL = 3'h0;
  localparam logic [2:0] MUX_SUPPLY = 3'h3;
  localparam logic [1:0] BREATHING_MEASURE_CTRL_OKAY = 2'h0;
  localparam logic [1:0] BREATHING_MEASURE_CTRL_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SRC_OPEN = 2'h0,
    SRC_DIFF = 2'h1,
    SRC_MID_SUPPLY = 2'h2,
    SRC_HALF_DIG = 2'h3
  } frio_src_e;
endpackage
`default_nettype wire

// ==== src/frio_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - one register: four pin values, four directions
// - respiration enabled hands pins to respiration
// - pace routing two selectors, buffer powerdown
// - pace writes only route and power
// - respiration fields: demod, mod, ref, phase, control
// - central terminal from chosen channel 1-4 inputs
// - augmented lead enables, amp A powerdown, select
// - amp B,C powerdowns and input selects
// - normal electrode passes inputs differentially
// - supply monitor: channel 3 half digital supply
module frio_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] io_pin_i,
  output logic [3:0] io_pin_o,
  output logic [3:0] io_pin_oe_n,
  output logic [1:0] odd_amp_channel_sel,
  output logic [1:0] even_amp_channel_sel,
  output logic pulse_buffer_powerdown,
  output logic breath_demod_enable,
  output logic breath_mod_enable,
  output logic breath_mod_reference,
  output logic [2:0] breath_phase,
  output logic [1:0] breath_control,
  output logic leg_lead_to_ch6,
  output logic left_arm_lead_to_ch5,
  output logic right_arm_lead_to_ch7,
  output logic right_arm_lead_to_ch4,
  output logic center_amp_a_powerdown,
  output logic [2:0] center_amp_a_select,
  output logic center_amp_b_powerdown,
  output logic [2:0] center_amp_b_select,
  output logic center_amp_c_powerdown,
  output logic [2:0] center_amp_c_select,
  output logic central_terminal_drive,
  output logic [15:0] channel_source
);
  logic [7:0] general_io_pins;
  logic [7:0] pace_amp_routing;
  logic [7:0] breathing_measure_ctrl;
  logic [7:0] center_terminal_aug_lead;
  logic [7:0] center_terminal_b_c;
  logic [7:0] mux_select;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [7:0] w_data;
  logic w_held;
  logic [7:0] next_rdata;
  logic rd_hit;
  logic wr_hit;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [7:0] pin_state;

  frio_pins_if pins ();

  frio_pin_ctl u_pin_ctl (
    .clk(clk),
    .rst_n(rst_n),
    .pins(pins)
  );

  // Either breath enable claims the pins
  assign pins.breathing_measure_ctrl_active = breathing_measure_ctrl[frio_pkg::BR_DEMOD_BIT]
    | breathing_measure_ctrl[frio_pkg::BR_MOD_BIT];
  assign pins.value = general_io_pins[7:frio_pkg::PIN_VAL_LSB];
  assign pins.dir_in = general_io_pins[frio_pkg::PIN_VAL_LSB-1:0];
  assign pins.pin_i = io_pin_i;
  assign io_pin_o = pins.pin_o;
  assign io_pin_oe_n = pins.pin_oe_n;
  assign pin_state = {4'h0, pins.read_back};

  // Write channel: address and data accepted in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      w_held <= 1'b0;
      w_data <= 8'h00;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      // Only lane 0 carries register bits
      w_data <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
    end
    else if (wr_fire)
      w_held <= 1'b0;
  end

  assign wr_fire = aw_held && w_held;
  assign wr_idx = {2'h0, aw_addr[7:2]};

  always_comb
  begin
    case (wr_idx)
      frio_pkg::IDX_IO_PINS,
      frio_pkg::IDX_PACE,
      frio_pkg::IDX_BREATH,
      frio_pkg::IDX_CT_AUG,
      frio_pkg::IDX_CT_BC,
      frio_pkg::IDX_MUX_SEL,
      frio_pkg::IDX_PIN_STATE: wr_hit = (aw_addr[1:0] == 2'h0);
      default: wr_hit = 1'b0;
    endcase
  end

  // A lane-0 strobe low leaves the register unchanged
  logic lane0;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lane0 <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready)
      lane0 <= s_axi_wstrb[0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      general_io_pins <= frio_pkg::RST_IO_PINS;
      pace_amp_routing <= frio_pkg::RST_PACE;
      breathing_measure_ctrl <= frio_pkg::RST_BREATH;
      center_terminal_aug_lead <= frio_pkg::RST_CT_AUG;
      center_terminal_b_c <= frio_pkg::RST_CT_BC;
      mux_select <= frio_pkg::RST_MUX_SEL;
    end
    else if (wr_fire && wr_hit && lane0 && aw_addr[1:0] == 2'h0)
    begin
      case (wr_idx)
        frio_pkg::IDX_IO_PINS: general_io_pins <= w_data;
        // Only routing and power bits; no mode change follows
        frio_pkg::IDX_PACE:
          pace_amp_routing <= w_data & frio_pkg::MASK_PACE;
        frio_pkg::IDX_BREATH: breathing_measure_ctrl <= w_data;
        frio_pkg::IDX_CT_AUG: center_terminal_aug_lead <= w_data;
        frio_pkg::IDX_CT_BC: center_terminal_b_c <= w_data;
        frio_pkg::IDX_MUX_SEL:
          mux_select <= w_data & frio_pkg::MASK_MUX_SEL;
        default:
          mux_select <= mux_select;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= frio_pkg::BREATHING_MEASURE_CTRL_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? frio_pkg::BREATHING_MEASURE_CTRL_OKAY : frio_pkg::BREATHING_MEASURE_CTRL_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read channel: one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx = {2'h0, s_axi_araddr[7:2]};

  always_comb
  begin
    next_rdata = 8'h00;
    rd_hit = (s_axi_araddr[1:0] == 2'h0);
    case (rd_idx)
      frio_pkg::IDX_IO_PINS: next_rdata = general_io_pins;
      frio_pkg::IDX_PACE: next_rdata = pace_amp_routing;
      frio_pkg::IDX_BREATH: next_rdata = breathing_measure_ctrl;
      frio_pkg::IDX_CT_AUG: next_rdata = center_terminal_aug_lead;
      frio_pkg::IDX_CT_BC: next_rdata = center_terminal_b_c;
      frio_pkg::IDX_MUX_SEL: next_rdata = mux_select;
      frio_pkg::IDX_PIN_STATE: next_rdata = pin_state;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= frio_pkg::BREATHING_MEASURE_CTRL_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      // Upper bits always zero; narrow registers sit low
      s_axi_rdata <= {24'h00_0000, rd_hit ? next_rdata : 8'h00};
      s_axi_rresp <= rd_hit ? frio_pkg::BREATHING_MEASURE_CTRL_OKAY : frio_pkg::BREATHING_MEASURE_CTRL_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pulse_buffer_powerdown <= 1'b0;
      odd_amp_channel_sel <= 2'h0;
      even_amp_channel_sel <= 2'h0;
    end
    else
    begin
      pulse_buffer_powerdown <=
        pace_amp_routing[frio_pkg::PACE_PD_BIT];
      odd_amp_channel_sel <=
        pace_amp_routing[frio_pkg::PACE_ODD_LSB +: 2];
      even_amp_channel_sel <=
        pace_amp_routing[frio_pkg::PACE_EVEN_LSB +: 2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      breath_demod_enable <= 1'b0;
      breath_mod_enable <= 1'b0;
      breath_mod_reference <= 1'b0;
      breath_phase <= 3'h0;
      breath_control <= 2'h0;
    end
    else
    begin
      breath_demod_enable <=
        breathing_measure_ctrl[frio_pkg::BR_DEMOD_BIT];
      breath_mod_enable <=
        breathing_measure_ctrl[frio_pkg::BR_MOD_BIT];
      breath_mod_reference <=
        breathing_measure_ctrl[frio_pkg::BR_REF_BIT];
      breath_phase <=
        breathing_measure_ctrl[frio_pkg::BR_PH_LSB +: 3];
      breath_control <=
        breathing_measure_ctrl[frio_pkg::BR_CTRL_LSB +: 2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      leg_lead_to_ch6 <= 1'b0;
      left_arm_lead_to_ch5 <= 1'b0;
      right_arm_lead_to_ch7 <= 1'b0;
      right_arm_lead_to_ch4 <= 1'b0;
      center_amp_a_powerdown <= 1'b0;
      center_amp_a_select <= 3'h0;
      center_amp_b_powerdown <= 1'b0;
      center_amp_b_select <= 3'h0;
      center_amp_c_powerdown <= 1'b0;
      center_amp_c_select <= 3'h0;
      central_terminal_drive <= 1'b0;
    end
    else
    begin
      leg_lead_to_ch6 <= center_terminal_aug_lead[7];
      left_arm_lead_to_ch5 <= center_terminal_aug_lead[6];
      right_arm_lead_to_ch7 <= center_terminal_aug_lead[5];
      right_arm_lead_to_ch4 <= center_terminal_aug_lead[4];
      center_amp_a_powerdown <=
        center_terminal_aug_lead[frio_pkg::CT_PD_A_BIT];
      center_amp_a_select <= center_terminal_aug_lead[2:0];
      center_amp_c_powerdown <=
        center_terminal_b_c[frio_pkg::CT_PD_C_BIT];
      center_amp_b_powerdown <=
        center_terminal_b_c[frio_pkg::CT_PD_B_BIT];
      center_amp_b_select <=
        center_terminal_b_c[frio_pkg::CT_SEL_B_LSB +: 3];
      center_amp_c_select <=
        center_terminal_b_c[frio_pkg::CT_SEL_C_LSB +: 3];
      // Selects pick any of the 8 ch1-4 inputs; drive while any amp is up
      central_terminal_drive <=
        !(center_terminal_aug_lead[frio_pkg::CT_PD_A_BIT]
        && center_terminal_b_c[frio_pkg::CT_PD_B_BIT]
        && center_terminal_b_c[frio_pkg::CT_PD_C_BIT]);
    end
  end

  // Per-channel input source, 2 bits per channel, channel 1 lowest
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      channel_source <= 16'h0000;
    else
    begin
      for (int ch = 0; ch < 8; ch++)
      begin
        if (mux_select[2:0] == frio_pkg::MUX_NORMAL)
          channel_source[2*ch +: 2] <= frio_pkg::SRC_DIFF;
        else if (mux_select[2:0] == frio_pkg::MUX_SUPPLY)
          channel_source[2*ch +: 2] <= (ch == 2) ?
            frio_pkg::SRC_HALF_DIG : frio_pkg::SRC_MID_SUPPLY;
        else
          channel_source[2*ch +: 2] <= frio_pkg::SRC_OPEN;
      end
    end
  end
endmodule
`default_nettype wire
